// ===== clock_source_mode_config.sv
// Clock source, divider, PLL power and calibration configuration logic
`include "clock_source_mode_config_defines.svh"

module clock_source_mode_config (
  // Clock and reset
  input  wire logic                                  core_clk_i,
  input  wire logic                                  rst_i,
  // Register access from the serial control port
  input  wire logic                                  reg_wr_i,
  input  wire logic                                  reg_rd_i,
  input  wire clock_source_mode_config_pkg::reg_addr_t reg_addr_i,
  input  wire clock_source_mode_config_pkg::reg_data_t reg_wdata_i,
  output clock_source_mode_config_pkg::reg_data_t    reg_rdata_o,
  // Nonvolatile storage
  input  wire logic                                  nvm_valid_i,
  input  wire clock_source_mode_config_pkg::config_image_t nvm_image_i,
  input  wire logic                                  nvm_save_req_i,
  output logic                                       nvm_save_o,
  output clock_source_mode_config_pkg::config_image_t nvm_save_image_o,
  // Clock path controls
  output logic                                       pll_enable_o,
  output logic                                       pfd_polarity_neg_o,
  output logic [2:0]                                 ref_enable_o,
  output logic [2:0]                                 osc_div_ratio_o,
  output logic                                       osc_div_bypass_o,
  output logic                                       source_internal_o,
  output logic                                       osc_power_on_o,
  output logic                                       prescaler_from_ext_o,
  // Calibration
  output logic                                       cal_start_o,
  output logic                                       cal_busy_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h0:    div_ratio = 3'h2;
      3'h1:    div_ratio = 3'h3;
      3'h2:    div_ratio = 3'h4;
      3'h3:    div_ratio = 3'h5;
      3'h4:    div_ratio = 3'h6;
      default: div_ratio = 3'h1;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Staged (written) and active copies
  // ----------------------------------------------------------------------
  logic [1:0] buf_power_ff;
  logic       buf_pol_ff;
  logic       buf_cal_ff;
  logic [2:0] buf_ref_ff;
  logic [2:0] buf_div_ff;
  logic [1:0] buf_sel_ff;
  logic [1:0] act_power_ff;
  logic       act_pol_ff;
  logic       act_cal_ff;
  logic [2:0] act_ref_ff;
  logic [2:0] act_div_ff;
  logic [1:0] act_sel_ff;
  logic       restore_ff;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire hit_pll  = (reg_addr_i == `OFS_PLL_CONTROL_POLARITY_POWER);
  wire hit_cal  = (reg_addr_i == `OFS_OSCILLATOR_CALIBRATION_CONTROL);
  wire hit_ref  = (reg_addr_i == `OFS_REFERENCE_INPUT_ENABLE);
  wire hit_div  = (reg_addr_i == `OFS_OSCILLATOR_DIVIDER_RATIO);
  wire hit_sel  = (reg_addr_i == `OFS_DISTRIBUTION_SOURCE_SELECT);
  wire hit_upd  = (reg_addr_i == `OFS_UPDATE_STROBE);
  wire update   = reg_wr_i && hit_upd && reg_wdata_i[`POS_UPDATE];
  wire restore  = restore_ff && nvm_valid_i;
  wire cal_busy;
  wire cal_done;

  // Calibration only on a 0 to 1 step of the active bit, so a stale set bit
  // cannot retrigger; software has to clear and update first
  wire cal_trigger = update && buf_cal_ff && !act_cal_ff;

  wire clock_source_mode_config_pkg::config_image_t act_image =
    {act_power_ff, act_pol_ff, act_ref_ff, act_div_ff, act_sel_ff};

  wire clock_source_mode_config_pkg::reg_data_t rd_mux =
    hit_pll ? {buf_pol_ff, 5'h00, buf_power_ff} :
    hit_cal ? {6'h00, cal_busy, buf_cal_ff} :
    hit_ref ? {5'h00, buf_ref_ff} :
    hit_div ? {5'h00, buf_div_ff} :
    hit_sel ? {6'h00, buf_sel_ff} :
    8'h00;

  wire pll_on = (act_power_ff == `PLL_POWER_NORMAL);
  wire src_int = act_sel_ff[`POS_SOURCE_INTERNAL];

  // ----------------------------------------------------------------------
  // Staged registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      buf_power_ff <= `RST_PLL_POWER;
      buf_pol_ff   <= `RST_PFD_POLARITY;
      buf_cal_ff   <= `RST_CALIBRATE;
      buf_ref_ff   <= `RST_REF_ENABLE;
      buf_div_ff   <= `RST_DIV_CODE;
      buf_sel_ff   <= {`RST_SOURCE_INTERNAL, `RST_DIV_BYPASS};
    end else if (restore) begin
      {buf_power_ff, buf_pol_ff, buf_ref_ff, buf_div_ff, buf_sel_ff} <= nvm_image_i;
    end else if (reg_wr_i) begin
      if (hit_pll) begin
        buf_power_ff <= reg_wdata_i[`POS_PLL_POWER_MSB:`POS_PLL_POWER_LSB];
        buf_pol_ff   <= reg_wdata_i[`POS_PFD_POLARITY];
      end
      if (hit_cal) begin
        buf_cal_ff <= reg_wdata_i[`POS_CALIBRATE];
      end
      if (hit_ref) begin
        buf_ref_ff <= reg_wdata_i[`POS_REF_ENABLE_MSB:0];
      end
      if (hit_div) begin
        buf_div_ff <= reg_wdata_i[`POS_DIV_CODE_MSB:0];
      end
      if (hit_sel) begin
        buf_sel_ff <= reg_wdata_i[`POS_SOURCE_INTERNAL:`POS_DIV_BYPASS];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Active registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      act_power_ff <= `RST_PLL_POWER;
      act_pol_ff   <= `RST_PFD_POLARITY;
      act_cal_ff   <= `RST_CALIBRATE;
      act_ref_ff   <= `RST_REF_ENABLE;
      act_div_ff   <= `RST_DIV_CODE;
      act_sel_ff   <= {`RST_SOURCE_INTERNAL, `RST_DIV_BYPASS};
    end else if (restore) begin
      {act_power_ff, act_pol_ff, act_ref_ff, act_div_ff, act_sel_ff} <= nvm_image_i;
    end else if (update) begin
      act_power_ff <= buf_power_ff;
      act_pol_ff   <= buf_pol_ff;
      act_cal_ff   <= buf_cal_ff;
      act_ref_ff   <= buf_ref_ff;
      act_div_ff   <= buf_div_ff;
      act_sel_ff   <= buf_sel_ff;
    end
  end

  // Restore window is the first cycle after reset release only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      restore_ff <= 1'b1;
    end else begin
      restore_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Calibration timer
  // ----------------------------------------------------------------------
  oscillator_cal_timer u_cal_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (cal_trigger),
    .busy_o     (cal_busy),
    .done_o     (cal_done)
  );

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o          <= 8'h00;
      nvm_save_o           <= 1'b0;
      nvm_save_image_o     <= '0;
      pll_enable_o         <= 1'b0;
      pfd_polarity_neg_o   <= 1'b0;
      ref_enable_o         <= 3'h0;
      osc_div_ratio_o      <= 3'h2;
      osc_div_bypass_o     <= 1'b0;
      source_internal_o    <= 1'b0;
      osc_power_on_o       <= 1'b0;
      prescaler_from_ext_o <= 1'b0;
      cal_start_o          <= 1'b0;
      cal_busy_o           <= 1'b0;
    end else begin
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
      nvm_save_o           <= nvm_save_req_i;
      if (nvm_save_req_i) begin
        nvm_save_image_o <= act_image;
      end
      pll_enable_o         <= pll_on;
      pfd_polarity_neg_o   <= act_pol_ff;
      ref_enable_o         <= act_ref_ff;
      osc_div_ratio_o      <= div_ratio(act_div_ff);
      osc_div_bypass_o     <= act_sel_ff[`POS_DIV_BYPASS];
      source_internal_o    <= src_int;
      osc_power_on_o       <= pll_on && src_int;
      prescaler_from_ext_o <= pll_on && !src_int;
      cal_start_o          <= cal_trigger;
      cal_busy_o           <= cal_busy || cal_trigger;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_stage_cal;
    reg_wr_i && hit_cal && reg_wdata_i[`POS_CALIBRATE] && !act_cal_ff;
  endsequence

  sequence s_strobe;
    update && !restore;
  endsequence

  sequence s_cal_strobe;
    update && buf_cal_ff && !act_cal_ff && !restore;
  endsequence

  AST_PLL_POWER: assert property (##1 1 |->
    ##1 (pll_enable_o == ($past(act_power_ff, 1) == `PLL_POWER_NORMAL)))
    else $error("pll enable does not follow power field");

  AST_SOURCE_SEL: assert property (##1 1 |->
    ##1 (source_internal_o == $past(act_sel_ff[`POS_SOURCE_INTERNAL], 1)))
    else $error("source select output wrong");

  AST_BYPASS: assert property (##1 1 |->
    ##1 (osc_div_bypass_o == $past(act_sel_ff[`POS_DIV_BYPASS], 1)))
    else $error("divider bypass output wrong");

  AST_DIV_CODE0: assert property ((act_div_ff == 3'h0) ##1 1 |->
    (osc_div_ratio_o == 3'h2))
    else $error("code zero not divide by two");

  // Strobe may follow the calibrate write directly or after one idle cycle
  AST_CAL_SEQ: assert property (s_stage_cal ##[1:2] s_cal_strobe |->
    ##1 cal_start_o ##1 cal_busy_o)
    else $error("calibration not started by strobe");

  AST_NO_RECAL: assert property (update && act_cal_ff |-> ##1 !cal_start_o)
    else $error("calibration retriggered without clear");

  AST_POLARITY: assert property (##1 1 |->
    ##1 (pfd_polarity_neg_o == $past(act_pol_ff, 1)))
    else $error("polarity output wrong");

  AST_RESET_DEFAULT: assert property (@(posedge core_clk_i)
    $fell(rst_i) && !nvm_valid_i |-> ##1 (!pll_enable_o && osc_div_ratio_o == 3'h2
      && !osc_div_bypass_o && !source_internal_o))
    else $error("reset defaults wrong");

  AST_EXT_OSC_OFF: assert property (pll_on && !src_int |->
    ##1 (!osc_power_on_o && prescaler_from_ext_o))
    else $error("oscillator not off with external source");

  AST_STAGED: assert property (!update && !restore |=> $stable(act_image))
    else $error("active config changed without strobe");

  AST_STROBE_COPY: assert property (s_strobe |=>
    (act_power_ff == $past(buf_power_ff) && act_div_ff == $past(buf_div_ff)))
    else $error("strobe did not copy staged values");

  AST_SAVE: assert property (nvm_save_req_i |=>
    (nvm_save_o && nvm_save_image_o == $past(act_image)))
    else $error("save image wrong");

  AST_CAL_END: assert property (cal_done && !cal_trigger |=> !cal_busy_o)
    else $error("busy stays high after calibration end");

  AST_CAL_ONCE: assert property (cal_start_o |=> !cal_start_o)
    else $error("calibration start longer than one cycle");

  AST_ACT_CAL_COPY: assert property (s_strobe |=>
    (act_cal_ff == $past(buf_cal_ff)))
    else $error("strobe did not copy calibrate bit");

endmodule

// ===== clock_source_mode_config_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CLOCK_SOURCE_MODE_CONFIG_DEFINES_SVH
`define CLOCK_SOURCE_MODE_CONFIG_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_PLL_CONTROL_POLARITY_POWER    10'h010
`define OFS_OSCILLATOR_CALIBRATION_CONTROL 10'h018
`define OFS_REFERENCE_INPUT_ENABLE        10'h01c
`define OFS_OSCILLATOR_DIVIDER_RATIO      10'h1e0
`define OFS_DISTRIBUTION_SOURCE_SELECT    10'h1e1
`define OFS_UPDATE_STROBE                 10'h232

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define POS_PLL_POWER_LSB   0
`define POS_PLL_POWER_MSB   1
`define POS_PFD_POLARITY    7
`define POS_CALIBRATE       0
`define POS_CAL_BUSY        1
`define POS_REF_ENABLE_MSB  2
`define POS_DIV_CODE_MSB    2
`define POS_DIV_BYPASS      0
`define POS_SOURCE_INTERNAL 1
`define POS_UPDATE          0

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define PLL_POWER_NORMAL    2'h0
`define PLL_POWER_ASYNC_PD  2'h1
`define RST_PLL_POWER       2'h1
`define RST_PFD_POLARITY    1'h0
`define RST_CALIBRATE       1'h0
`define RST_REF_ENABLE      3'h0
`define RST_DIV_CODE        3'h0
`define RST_DIV_BYPASS      1'h0
`define RST_SOURCE_INTERNAL 1'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_MHZ        10
`define CAL_TIME_NS         1000
`define CAL_CYCLES          ((`CAL_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

// ===== clock_source_mode_config_pkg.sv
// Shared types of the clock source mode configuration block
package clock_source_mode_config_pkg;

  typedef logic [7:0]  reg_data_t;
  typedef logic [9:0]  reg_addr_t;
  typedef logic [10:0] config_image_t;

  typedef enum logic {
    CAL_IDLE,
    CAL_RUN
  } cal_state_e;

endpackage

// ===== clock_source_mode_config_tb_top.sv
// Self-checking testbench of the clock source mode configuration block
`include "clock_source_mode_config_defines.svh"

module clock_source_mode_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                                        core_clk_i;
  logic                                        rst_i;
  logic                                        reg_wr_i;
  logic                                        reg_rd_i;
  clock_source_mode_config_pkg::reg_addr_t     reg_addr_i;
  clock_source_mode_config_pkg::reg_data_t     reg_wdata_i;
  clock_source_mode_config_pkg::reg_data_t     reg_rdata_o;
  logic                                        nvm_valid_i;
  clock_source_mode_config_pkg::config_image_t nvm_image_i;
  logic                                        nvm_save_req_i;
  logic                                        nvm_save_o;
  clock_source_mode_config_pkg::config_image_t nvm_save_image_o;
  logic                                        pll_enable_o;
  logic                                        pfd_polarity_neg_o;
  logic [2:0]                                  ref_enable_o;
  logic [2:0]                                  osc_div_ratio_o;
  logic                                        osc_div_bypass_o;
  logic                                        source_internal_o;
  logic                                        osc_power_on_o;
  logic                                        prescaler_from_ext_o;
  logic                                        cal_start_o;
  logic                                        cal_busy_o;
  int                                          failures;
  int                                          checks_done;
  bit                                          seen;
  logic                                        pll_on;

  clock_source_mode_config clock_source_mode_config_inst (
    .core_clk_i          (core_clk_i),
    .rst_i               (rst_i),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_addr_i          (reg_addr_i),
    .reg_wdata_i         (reg_wdata_i),
    .reg_rdata_o         (reg_rdata_o),
    .nvm_valid_i         (nvm_valid_i),
    .nvm_image_i         (nvm_image_i),
    .nvm_save_req_i      (nvm_save_req_i),
    .nvm_save_o          (nvm_save_o),
    .nvm_save_image_o    (nvm_save_image_o),
    .pll_enable_o        (pll_enable_o),
    .pfd_polarity_neg_o  (pfd_polarity_neg_o),
    .ref_enable_o        (ref_enable_o),
    .osc_div_ratio_o     (osc_div_ratio_o),
    .osc_div_bypass_o    (osc_div_bypass_o),
    .source_internal_o   (source_internal_o),
    .osc_power_on_o      (osc_power_on_o),
    .prescaler_from_ext_o(prescaler_from_ext_o),
    .cal_start_o         (cal_start_o),
    .cal_busy_o          (cal_busy_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input clock_source_mode_config_pkg::reg_addr_t a,
                    input clock_source_mode_config_pkg::reg_data_t d);
    @(negedge core_clk_i);
    reg_wr_i    = 1'b1;
    reg_addr_i  = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input clock_source_mode_config_pkg::reg_addr_t a,
                    input clock_source_mode_config_pkg::reg_data_t exp);
    @(negedge core_clk_i);
    reg_rd_i   = 1'b1;
    reg_addr_i = a;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask

  // Outputs trail the active copy by one cycle, hence the extra edge
  task automatic upd();
    wr(`OFS_UPDATE_STROBE, 8'h01);
    @(negedge core_clk_i);
  endtask

  // The strobe write returns while the one-cycle start pulse still stands
  task automatic watch_start(output bit hit);
    hit = (cal_start_o === 1'b1);
    repeat (4) begin
      @(negedge core_clk_i);
      if (cal_start_o === 1'b1) hit = 1'b1;
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (cal_busy_o !== 1'b0) begin
      @(negedge core_clk_i);
      n++;
      if (n > 40) begin
        failures++;
        summarize();
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    failures = 0;
    checks_done = 0;
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 10'h000;
    reg_wdata_i = 8'h00;
    nvm_valid_i = 1'b0;
    nvm_image_i = 11'h000;
    nvm_save_req_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk(pll_enable_o, 1'b0);
    chk(osc_div_ratio_o, 3'h2);
    chk({source_internal_o, osc_div_bypass_o}, 2'h0);
    rd(`OFS_PLL_CONTROL_POLARITY_POWER, 8'h01);
    rd(`OFS_OSCILLATOR_DIVIDER_RATIO, 8'h00);
    rd(`OFS_DISTRIBUTION_SOURCE_SELECT, 8'h00);
    // Staged write must not leak before the strobe
    wr(`OFS_DISTRIBUTION_SOURCE_SELECT, 8'h02);
    repeat (2) @(negedge core_clk_i);
    chk(source_internal_o, 1'b0);
    upd();
    chk(source_internal_o, 1'b1);
    // Reserved bits, unmapped place and strobe readback
    wr(`OFS_DISTRIBUTION_SOURCE_SELECT, 8'hfc);
    rd(`OFS_DISTRIBUTION_SOURCE_SELECT, 8'h00);
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
    rd(`OFS_UPDATE_STROBE, 8'h00);
    // Every power code, polarity, source and bypass combination
    for (int i = 0; i < 32; i++) begin
      wr(`OFS_PLL_CONTROL_POLARITY_POWER, {i[2], 5'h00, i[1:0]});
      wr(`OFS_DISTRIBUTION_SOURCE_SELECT, {6'h00, i[4:3]});
      upd();
      pll_on = (i[1:0] == 2'h0);
      chk(pll_enable_o, pll_on);
      chk(pfd_polarity_neg_o, i[2]);
      chk(source_internal_o, i[4]);
      chk(osc_div_bypass_o, i[3]);
      chk(osc_power_on_o, pll_on & i[4]);
      chk(prescaler_from_ext_o, pll_on & ~i[4]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_OSCILLATOR_DIVIDER_RATIO, {5'h00, c[2:0]});
      upd();
      chk(osc_div_ratio_o, (c < 5) ? c[2:0] + 3'h2 : 3'h1);
    end
    // Calibration: first run, refused repeat, then clear and rerun
    wr(`OFS_OSCILLATOR_CALIBRATION_CONTROL, 8'h01);
    wr(`OFS_UPDATE_STROBE, 8'h01);
    watch_start(seen);
    chk(seen, 1'b1);
    rd(`OFS_OSCILLATOR_CALIBRATION_CONTROL, 8'h03);
    chk(cal_busy_o, 1'b1);
    wait_idle();
    wr(`OFS_UPDATE_STROBE, 8'h01);
    watch_start(seen);
    chk(seen, 1'b0);
    wr(`OFS_OSCILLATOR_CALIBRATION_CONTROL, 8'h00);
    wr(`OFS_UPDATE_STROBE, 8'h01);
    watch_start(seen);
    chk(seen, 1'b0);
    wr(`OFS_OSCILLATOR_CALIBRATION_CONTROL, 8'h01);
    wr(`OFS_UPDATE_STROBE, 8'h01);
    watch_start(seen);
    chk(seen, 1'b1);
    wait_idle();
    // Save the active configuration to storage
    wr(`OFS_PLL_CONTROL_POLARITY_POWER, 8'h80);
    wr(`OFS_REFERENCE_INPUT_ENABLE, 8'h05);
    wr(`OFS_OSCILLATOR_DIVIDER_RATIO, 8'h03);
    wr(`OFS_DISTRIBUTION_SOURCE_SELECT, 8'h02);
    upd();
    chk(ref_enable_o, 3'h5);
    @(negedge core_clk_i);
    nvm_save_req_i = 1'b1;
    @(negedge core_clk_i);
    nvm_save_req_i = 1'b0;
    chk(nvm_save_o, 1'b1);
    chk(nvm_save_image_o, {2'h0, 1'b1, 3'h5, 3'h3, 2'h2});
    @(negedge core_clk_i);
    chk(nvm_save_o, 1'b0);
    // Restore from storage on reset release, no register traffic
    nvm_valid_i = 1'b1;
    nvm_image_i = {2'h0, 1'b0, 3'h2, 3'h4, 2'h2};
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    nvm_valid_i = 1'b0;
    chk({pll_enable_o, pfd_polarity_neg_o, ref_enable_o}, 5'h12);
    chk({osc_div_ratio_o, source_internal_o, osc_div_bypass_o}, 5'h1a);
    chk(osc_power_on_o, 1'b1);
    rd(`OFS_OSCILLATOR_DIVIDER_RATIO, 8'h04);
    summarize();
  end
endmodule

// ===== oscillator_cal_timer.sv
// Oscillator calibration timer: runs a fixed-length calibration on start
`include "clock_source_mode_config_defines.svh"

module oscillator_cal_timer (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic start_i,
  // Status
  output logic      busy_o,
  output logic      done_o
);

  localparam logic [7:0] CAL_LAST = 8'(`CAL_CYCLES - 1);

  clock_source_mode_config_pkg::cal_state_e state_ff;
  clock_source_mode_config_pkg::cal_state_e nxt_state;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic       nxt_done;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      clock_source_mode_config_pkg::CAL_IDLE: begin
        if (start_i) begin
          nxt_state = clock_source_mode_config_pkg::CAL_RUN;
          nxt_count = 8'h00;
        end
      end
      clock_source_mode_config_pkg::CAL_RUN: begin
        if (count_ff == CAL_LAST) begin
          nxt_state = clock_source_mode_config_pkg::CAL_IDLE;
          nxt_done  = 1'b1;
        end else begin
          nxt_count = count_ff + 8'h01;
        end
      end
      default: begin
        nxt_state = clock_source_mode_config_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_ff <= clock_source_mode_config_pkg::CAL_IDLE;
      count_ff <= 8'h00;
      done_o   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      done_o   <= nxt_done;
    end
  end

  assign busy_o = (state_ff == clock_source_mode_config_pkg::CAL_RUN);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Run length counted here, too long for a repetition in a property
  logic [7:0] busy_len_ff;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !busy_o) begin
      busy_len_ff <= 8'h00;
    end else begin
      busy_len_ff <= busy_len_ff + 8'h01;
    end
  end

  AST_CAL_LENGTH: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(busy_o) |-> (done_o && busy_len_ff == CAL_LAST + 8'h01))
    else $error("calibration length wrong");

  AST_CAL_BOUND: assert property (@(posedge core_clk_i) disable iff (rst_i)
    busy_o |-> (busy_len_ff <= CAL_LAST))
    else $error("calibration ran too long");

endmodule
